// File: inc/pcs_pkg.sv
// Purpose: Constants for the configuration status register block
// Assumes: 16-bit status word, byte-lane write strobes
// Notes:   Offsets are configuration space byte addresses
package pcs_pkg;
  localparam logic [7:0]  CMD_OFFSET        = 8'h04;
  localparam logic [7:0]  STATUS_OFFSET     = 8'h06;
  localparam int          BIT_PARITY_SEEN   = 15;
  localparam int          BIT_SYS_SIGNALLED = 14;
  localparam int          BIT_MASTER_ABORT_RECEIVED_RCVD   = 13;
  localparam int          BIT_TABORT_RCVD   = 12;
  localparam int          BIT_TARGET_ABORT_SIGNALLED    = 11;
  localparam int          BIT_MDATA_PARITY  = 8;
  localparam int          BIT_INT_PENDING   = 3;
  localparam int          CMD_BIT_INT_DIS   = 10;
  localparam int          CMD_BIT_SYS_EN    = 8;
  localparam int          CMD_BIT_PAR_EN    = 6;
  localparam logic [1:0]  DEVSEL_MEDIUM     = 2'h1;
  localparam logic [15:0] STATUS_RESET      = 16'h0210;
  localparam logic [15:0] CMD_RESET         = 16'h0000;
  localparam logic [15:0] CMD_WRITE_MASK    = 16'h0556;
endpackage

// File: design/pcs_sticky_flag.sv
// Purpose: One write-one-to-clear event flag
// Assumes: Event and clear are on the same clock
// Notes:   Set wins over a clear in the same cycle
`timescale 1ns/1ps
`default_nettype none
module pcs_sticky_flag (
  input  wire logic clk_in,
  input  wire logic arst_n_in,
  input  wire logic set_in,
  input  wire logic clear_in,
  output var  logic flag_out
);
  always_ff @(posedge clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      flag_out <= 1'b0;
    end else if (set_in) begin
      flag_out <= 1'b1;
    end else if (clear_in) begin
      flag_out <= 1'b0;
    end
  end
endmodule
`default_nettype wire

// File: design/pcs_status_reg.sv
// Purpose: Configuration status register with command enables it relies on
// Assumes: Config access port on the bus clock; events are one-cycle pulses
// Notes:   Read data is registered, one cycle after the read strobe
`timescale 1ns/1ps
`default_nettype none
// Functional notes
// - Parity error on address/data sets bit 15
// - Signalled system error sets bit 14
// - Own cycle master-aborted sets bit 13
// - Own cycle target-aborted sets bit 12
// - Our target abort sets bit 11
// - Bits 10:9 read 01, medium select
// - Bit 8: perr, we mastered, enabled
// - Bit 7 reads zero
// - Bit 6 reads zero
// - Bit 5 reads zero, not fast clock
// - Bit 4 reads one, capability list
// - Bit 3 pending; interrupt when not disabled
// - Interrupt disable only masks the output
// - Compliance off forces bit 3 zero
// - Bits 2:0 read zero, writes ignored
// - System fault driven only when enabled
module pcs_status_reg (
  // Clock and reset
  input  wire logic        CLOCK_IN,
  input  wire logic        ARST_N_IN,
  // Configuration access
  input  wire logic [7:0]  CFG_ADDR_IN,
  input  wire logic        CFG_WR_IN,
  input  wire logic        CFG_RD_IN,
  input  wire logic [1:0]  CFG_BE_IN,
  input  wire logic [15:0] CFG_WDATA_IN,
  output var  logic [15:0] CFG_RDATA_OUT,
  // Bus events
  input  wire logic        ADDR_PARITY_ERR_IN,
  input  wire logic        DATA_PARITY_ERR_IN,
  input  wire logic        PERR_SEEN_IN,
  input  wire logic        IS_MASTER_IN,
  input  wire logic        MASTER_ABORT_IN,
  input  wire logic        TARGET_ABORT_RCVD_IN,
  input  wire logic        TARGET_ABORT_SENT_IN,
  input  wire logic        SYS_FAULT_REQ_IN,
  input  wire logic        CFG_CYCLE_IN,
  // Function state
  input  wire logic        INT_REQ_IN,
  input  wire logic        NEWER_REV_COMPLIANCE_ENABLE_IN,
  // Outputs
  output var  logic        INT_ASSERT_OUT,
  output var  logic        SYSTEM_FAULT_OUT,
  output var  logic        DEVSEL_MEDIUM_OUT,
  output var  logic        PARITY_RESPONSE_ENABLE_OUT
);
  logic [15:0] cmd_reg;
  logic [15:0] status_word;
  logic        wr_status;
  logic [15:0] clr_mask;
  logic        sys_fault_driver_enable;
  logic        parity_response_enable;
  logic        int_disable;
  logic        int_pending;
  logic        fault_fire;
  logic        parity_fault_seen;
  logic        system_fault_signalled;
  logic        master_abort_received;
  logic        target_abort_received;
  logic        target_abort_signalled;
  logic        master_data_parity_flag;
  logic [15:0] byte_lanes;
  logic        wr_command;
  logic [15:0] cmd_next;
  logic        parity_set;
  logic        system_fault_set;
  logic        master_abort_set;
  logic        target_abort_rcvd_set;
  logic        target_abort_sent_set;
  logic        master_parity_set;

  assign sys_fault_driver_enable = cmd_reg[pcs_pkg::CMD_BIT_SYS_EN];
  assign parity_response_enable  = cmd_reg[pcs_pkg::CMD_BIT_PAR_EN];
  assign int_disable             = cmd_reg[pcs_pkg::CMD_BIT_INT_DIS];
  assign byte_lanes  = {{8{CFG_BE_IN[1]}}, {8{CFG_BE_IN[0]}}};
  assign wr_status   = CFG_WR_IN && (CFG_ADDR_IN == pcs_pkg::STATUS_OFFSET);
  assign wr_command  = CFG_WR_IN && (CFG_ADDR_IN == pcs_pkg::CMD_OFFSET);
  assign clr_mask    = wr_status ? (CFG_WDATA_IN & byte_lanes) : 16'h0000;
  assign int_pending = INT_REQ_IN && NEWER_REV_COMPLIANCE_ENABLE_IN;
  assign fault_fire  = sys_fault_driver_enable && (SYS_FAULT_REQ_IN || ADDR_PARITY_ERR_IN);

  // Event qualifiers; received abort kinds only count while this function owns the bus
  assign parity_set            = ADDR_PARITY_ERR_IN || DATA_PARITY_ERR_IN;
  assign system_fault_set      = fault_fire;
  assign master_abort_set      = MASTER_ABORT_IN && IS_MASTER_IN;
  assign target_abort_rcvd_set = TARGET_ABORT_RCVD_IN && IS_MASTER_IN;
  assign target_abort_sent_set = TARGET_ABORT_SENT_IN;
  assign master_parity_set     = PERR_SEEN_IN && IS_MASTER_IN && parity_response_enable;

  // Command write keeps lanes that are not enabled; unmasked bits stay zero
  always_comb begin
    cmd_next = (cmd_reg & ~byte_lanes) | (CFG_WDATA_IN & byte_lanes);
    cmd_next = cmd_next & pcs_pkg::CMD_WRITE_MASK;
    if (!NEWER_REV_COMPLIANCE_ENABLE_IN) begin
      cmd_next[pcs_pkg::CMD_BIT_INT_DIS] = 1'b0;
    end
  end

  // Interrupt disable is read-only zero without compliance
  always_ff @(posedge CLOCK_IN or negedge ARST_N_IN) begin
    if (!ARST_N_IN) begin
      cmd_reg <= pcs_pkg::CMD_RESET;
    end else if (wr_command) begin
      cmd_reg <= cmd_next;
    end else if (!NEWER_REV_COMPLIANCE_ENABLE_IN) begin
      cmd_reg[pcs_pkg::CMD_BIT_INT_DIS] <= 1'b0;
    end
  end

  pcs_sticky_flag u_par (
    .clk_in   (CLOCK_IN),
    .arst_n_in(ARST_N_IN),
    .set_in   (parity_set),
    .clear_in (clr_mask[pcs_pkg::BIT_PARITY_SEEN]),
    .flag_out (parity_fault_seen)
  );

  pcs_sticky_flag u_sys (
    .clk_in   (CLOCK_IN),
    .arst_n_in(ARST_N_IN),
    .set_in   (system_fault_set),
    .clear_in (clr_mask[pcs_pkg::BIT_SYS_SIGNALLED]),
    .flag_out (system_fault_signalled)
  );

  pcs_sticky_flag u_mab (
    .clk_in   (CLOCK_IN),
    .arst_n_in(ARST_N_IN),
    .set_in   (master_abort_set),
    .clear_in (clr_mask[pcs_pkg::BIT_MASTER_ABORT_RECEIVED_RCVD]),
    .flag_out (master_abort_received)
  );

  pcs_sticky_flag u_tar (
    .clk_in   (CLOCK_IN),
    .arst_n_in(ARST_N_IN),
    .set_in   (target_abort_rcvd_set),
    .clear_in (clr_mask[pcs_pkg::BIT_TABORT_RCVD]),
    .flag_out (target_abort_received)
  );

  pcs_sticky_flag u_tas (
    .clk_in   (CLOCK_IN),
    .arst_n_in(ARST_N_IN),
    .set_in   (target_abort_sent_set),
    .clear_in (clr_mask[pcs_pkg::BIT_TARGET_ABORT_SIGNALLED]),
    .flag_out (target_abort_signalled)
  );

  pcs_sticky_flag u_mdp (
    .clk_in   (CLOCK_IN),
    .arst_n_in(ARST_N_IN),
    .set_in   (master_parity_set),
    .clear_in (clr_mask[pcs_pkg::BIT_MDATA_PARITY]),
    .flag_out (master_data_parity_flag)
  );

  always_comb begin
    status_word       = 16'h0000;
    status_word[15]   = parity_fault_seen;
    status_word[14]   = system_fault_signalled;
    status_word[13]   = master_abort_received;
    status_word[12]   = target_abort_received;
    status_word[11]   = target_abort_signalled;
    status_word[10:9] = pcs_pkg::DEVSEL_MEDIUM;
    status_word[8]    = master_data_parity_flag;
    status_word[4]    = pcs_pkg::STATUS_RESET[4];
    status_word[3]    = int_pending;
  end

  // Registered read data; unmapped offsets read zero
  always_ff @(posedge CLOCK_IN or negedge ARST_N_IN) begin
    if (!ARST_N_IN) begin
      CFG_RDATA_OUT <= 16'h0000;
    end else if (CFG_RD_IN) begin
      if (CFG_ADDR_IN == pcs_pkg::STATUS_OFFSET) begin
        CFG_RDATA_OUT <= status_word;
      end else if (CFG_ADDR_IN == pcs_pkg::CMD_OFFSET) begin
        CFG_RDATA_OUT <= cmd_reg;
      end else begin
        CFG_RDATA_OUT <= 16'h0000;
      end
    end
  end

  always_ff @(posedge CLOCK_IN or negedge ARST_N_IN) begin
    if (!ARST_N_IN) begin
      INT_ASSERT_OUT <= 1'b0;
    end else begin
      INT_ASSERT_OUT <= int_pending && !int_disable;
    end
  end

  always_ff @(posedge CLOCK_IN or negedge ARST_N_IN) begin
    if (!ARST_N_IN) begin
      SYSTEM_FAULT_OUT <= 1'b0;
    end else begin
      SYSTEM_FAULT_OUT <= fault_fire;
    end
  end

  always_ff @(posedge CLOCK_IN or negedge ARST_N_IN) begin
    if (!ARST_N_IN) begin
      DEVSEL_MEDIUM_OUT <= 1'b0;
    end else begin
      DEVSEL_MEDIUM_OUT <= !CFG_CYCLE_IN;
    end
  end

  always_ff @(posedge CLOCK_IN or negedge ARST_N_IN) begin
    if (!ARST_N_IN) begin
      PARITY_RESPONSE_ENABLE_OUT <= 1'b0;
    end else begin
      PARITY_RESPONSE_ENABLE_OUT <= parity_response_enable;
    end
  end
endmodule
`default_nettype wire

// File: sim/pcs_status_properties.sv
// Purpose: Port checks for the status register block
// Assumes: One clock, reset low
// Notes:   Bound to the top module
`timescale 1ns/1ps
`default_nettype none
module pcs_status_properties (
  input wire logic        CLOCK_IN, ARST_N_IN, CFG_WR_IN, CFG_RD_IN, CFG_CYCLE_IN, INT_REQ_IN,
  input wire logic        NEWER_REV_COMPLIANCE_ENABLE_IN, SYS_FAULT_REQ_IN, ADDR_PARITY_ERR_IN,
  input wire logic [7:0]  CFG_ADDR_IN,
  input wire logic [1:0]  CFG_BE_IN,
  input wire logic [15:0] CFG_WDATA_IN, CFG_RDATA_OUT,
  input wire logic        INT_ASSERT_OUT, SYSTEM_FAULT_OUT, DEVSEL_MEDIUM_OUT, PARITY_RESPONSE_ENABLE_OUT
);
  default clocking @(posedge CLOCK_IN); endclocking
  default disable iff (!ARST_N_IN);
  wire logic rs = CFG_RD_IN && CFG_ADDR_IN == 8'h06;
  wire logic ru = CFG_RD_IN && CFG_ADDR_IN != 8'h06 && CFG_ADDR_IN != 8'h04;
  devsel_medium_a: assert property (!CFG_CYCLE_IN |=> DEVSEL_MEDIUM_OUT) else $error("devsel");
  devsel_cfg_a: assert property (CFG_CYCLE_IN |=> !DEVSEL_MEDIUM_OUT) else $error("devsel cfg");
  fixed_bits_a: assert property (rs |=> CFG_RDATA_OUT[10:9] == 2'h1 && CFG_RDATA_OUT[7:4] == 4'h1
    && CFG_RDATA_OUT[2:0] == 3'h0) else $error("fixed bits");
  int_gate_a: assert property (INT_ASSERT_OUT |-> $past(INT_REQ_IN && NEWER_REV_COMPLIANCE_ENABLE_IN))
    else $error("int gate");
  pending_off_a: assert property (rs && !NEWER_REV_COMPLIANCE_ENABLE_IN |=> !CFG_RDATA_OUT[3])
    else $error("bit3");
  unmapped_zero_a: assert property (ru |=> CFG_RDATA_OUT == 16'h0) else $error("unmapped");
  fault_cause_a: assert property (SYSTEM_FAULT_OUT |-> $past(SYS_FAULT_REQ_IN || ADDR_PARITY_ERR_IN))
    else $error("fault");
  par_enable_a: assert property (CFG_WR_IN && CFG_ADDR_IN == 8'h04 && CFG_BE_IN[0]
    ##1 !(CFG_WR_IN && CFG_ADDR_IN == 8'h04)
    |=> PARITY_RESPONSE_ENABLE_OUT == $past(CFG_WDATA_IN[6], 2)) else $error("par en");
  fault_c: cover property (SYSTEM_FAULT_OUT);
  int_c: cover property (INT_ASSERT_OUT);
  pending_c: cover property (rs && NEWER_REV_COMPLIANCE_ENABLE_IN);
endmodule
bind pcs_status_reg pcs_status_properties u_props (
  .CLOCK_IN                      (CLOCK_IN),
  .ARST_N_IN                     (ARST_N_IN),
  .CFG_WR_IN                     (CFG_WR_IN),
  .CFG_RD_IN                     (CFG_RD_IN),
  .CFG_CYCLE_IN                  (CFG_CYCLE_IN),
  .INT_REQ_IN                    (INT_REQ_IN),
  .NEWER_REV_COMPLIANCE_ENABLE_IN(NEWER_REV_COMPLIANCE_ENABLE_IN),
  .SYS_FAULT_REQ_IN              (SYS_FAULT_REQ_IN),
  .ADDR_PARITY_ERR_IN            (ADDR_PARITY_ERR_IN),
  .CFG_ADDR_IN                   (CFG_ADDR_IN),
  .CFG_BE_IN                     (CFG_BE_IN),
  .CFG_WDATA_IN                  (CFG_WDATA_IN),
  .CFG_RDATA_OUT                 (CFG_RDATA_OUT),
  .INT_ASSERT_OUT                (INT_ASSERT_OUT),
  .SYSTEM_FAULT_OUT              (SYSTEM_FAULT_OUT),
  .DEVSEL_MEDIUM_OUT             (DEVSEL_MEDIUM_OUT),
  .PARITY_RESPONSE_ENABLE_OUT    (PARITY_RESPONSE_ENABLE_OUT)
);
`default_nettype wire

// File: sim/pcs_bus_agent.sv
// Purpose: Bus agents raising one event pulse per request
// Assumes: Same clock as the block
// Notes:   Event index picks the kind
`timescale 1ns/1ps
`default_nettype none
module pcs_bus_agent (
  input  wire logic       clk_in,
  input  wire logic       go_in,
  input  wire logic [2:0] kind_in,
  output var  logic [6:0] event_out
);
  always_ff @(posedge clk_in) event_out <= go_in ? 7'h1 << kind_in : 7'h0;
endmodule
`default_nettype wire

// File: sim/tb.sv
// Purpose: Self-checking bench for the status register
// Assumes: Inputs move 1 ns after the edge
// Notes:   Events come from the bus agent
`timescale 1ns/1ps
`default_nettype none
module tb;
  logic CLOCK_IN = 1'h0, ARST_N_IN = 1'h0, CFG_WR_IN = 1'h0, CFG_RD_IN = 1'h0, CFG_CYCLE_IN = 1'h0;
  logic INT_REQ_IN = 1'h0, NEWER_REV_COMPLIANCE_ENABLE_IN = 1'h0, IS_MASTER_IN = 1'h0, go = 1'h0;
  logic live = 1'h0;
  logic [7:0] CFG_ADDR_IN = 8'h0;
  logic [1:0] CFG_BE_IN = 2'h3;
  logic [15:0] CFG_WDATA_IN = 16'h0, e;
  logic [2:0] kind = 3'h0, b;
  logic [6:0] ev;
  logic [31:0] r = 32'h3d33, q = 32'h3d33;
  wire logic [15:0] CFG_RDATA_OUT;
  wire logic INT_ASSERT_OUT, SYSTEM_FAULT_OUT, DEVSEL_MEDIUM_OUT, PARITY_RESPONSE_ENABLE_OUT;
  wire logic ADDR_PARITY_ERR_IN = ev[0], DATA_PARITY_ERR_IN = ev[1], PERR_SEEN_IN = ev[2], MASTER_ABORT_IN = ev[3];
  wire logic TARGET_ABORT_RCVD_IN = ev[4], TARGET_ABORT_SENT_IN = ev[5], SYS_FAULT_REQ_IN = ev[6];
  int mismatches = 0, n_checks = 0;
  pcs_status_reg u_dut (
    .CLOCK_IN                      (CLOCK_IN),
    .ARST_N_IN                     (ARST_N_IN),
    .CFG_ADDR_IN                   (CFG_ADDR_IN),
    .CFG_WR_IN                     (CFG_WR_IN),
    .CFG_RD_IN                     (CFG_RD_IN),
    .CFG_BE_IN                     (CFG_BE_IN),
    .CFG_WDATA_IN                  (CFG_WDATA_IN),
    .CFG_RDATA_OUT                 (CFG_RDATA_OUT),
    .ADDR_PARITY_ERR_IN            (ADDR_PARITY_ERR_IN),
    .DATA_PARITY_ERR_IN            (DATA_PARITY_ERR_IN),
    .PERR_SEEN_IN                  (PERR_SEEN_IN),
    .IS_MASTER_IN                  (IS_MASTER_IN),
    .MASTER_ABORT_IN               (MASTER_ABORT_IN),
    .TARGET_ABORT_RCVD_IN          (TARGET_ABORT_RCVD_IN),
    .TARGET_ABORT_SENT_IN          (TARGET_ABORT_SENT_IN),
    .SYS_FAULT_REQ_IN              (SYS_FAULT_REQ_IN),
    .CFG_CYCLE_IN                  (CFG_CYCLE_IN),
    .INT_REQ_IN                    (INT_REQ_IN),
    .NEWER_REV_COMPLIANCE_ENABLE_IN(NEWER_REV_COMPLIANCE_ENABLE_IN),
    .INT_ASSERT_OUT                (INT_ASSERT_OUT),
    .SYSTEM_FAULT_OUT              (SYSTEM_FAULT_OUT),
    .DEVSEL_MEDIUM_OUT             (DEVSEL_MEDIUM_OUT),
    .PARITY_RESPONSE_ENABLE_OUT    (PARITY_RESPONSE_ENABLE_OUT)
  );
  pcs_bus_agent u_agent (.clk_in(CLOCK_IN), .go_in(go), .kind_in(kind), .event_out(ev));
  function automatic logic [31:0] lfsr(input logic [31:0] x);
    return {x[30:0], x[31] ^ x[21] ^ x[1] ^ x[0]};
  endfunction
  // Status word after event k with master m, parity enable p, fault enable s
  function automatic logic [15:0] exp_st(input logic [2:0] k, input logic m, p, s);
    exp_st = 16'h0210;
    case (k)
      3'h0: exp_st[15:14] = {1'h1, s};
      3'h1: exp_st[15] = 1'h1;
      3'h2: exp_st[8] = m & p;
      3'h3: exp_st[13] = m;
      3'h4: exp_st[12] = m;
      3'h5: exp_st[11] = 1'h1;
      default: exp_st[14] = s;
    endcase
  endfunction
  task automatic chk(input string what, input logic [15:0] exp, got);
    n_checks++;
    if (got !== exp) begin
      mismatches++;
      $display("Error %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic wcfg(input logic [7:0] a, input logic [15:0] d);
    @(posedge CLOCK_IN) #1 {CFG_ADDR_IN, CFG_WDATA_IN, CFG_WR_IN} = {a, d, 1'h1};
    @(posedge CLOCK_IN) #1 CFG_WR_IN = 1'h0;
  endtask
  task automatic rd(input logic [7:0] a, input logic [15:0] exp);
    @(posedge CLOCK_IN) #1 {CFG_ADDR_IN, CFG_RD_IN} = {a, 1'h1};
    @(posedge CLOCK_IN) #1 CFG_RD_IN = 1'h0;
    chk("read data", exp, CFG_RDATA_OUT);
  endtask
  task automatic finish_test;
    $display("Checks %0d mismatches %0d", n_checks, mismatches);
    if (mismatches == 0 && n_checks > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask
  always #25 CLOCK_IN = ~CLOCK_IN;
  // Select timing follows the cycle kind seen at the previous edge
  always @(posedge CLOCK_IN) begin
    live = ARST_N_IN;
    #1 q = lfsr(q);
    if (live) chk("devsel", {15'h0, !CFG_CYCLE_IN}, {15'h0, DEVSEL_MEDIUM_OUT});
    CFG_CYCLE_IN = q[0];
  end
  initial begin
    #(2000 * 50);
    mismatches++;
    finish_test;
  end
  initial begin
    repeat (20) @(posedge CLOCK_IN);
    #1 ARST_N_IN = 1'h1;
    rd(8'h06, 16'h0210);
    rd(8'h08, 16'h0);
    // First pass with fault enable, parity enable and master all set, then random ones
    for (int i = 0; i < 28; i++) begin
      r = lfsr(r);
      b = i < 7 ? 3'h7 : r[2:0];
      IS_MASTER_IN = b[2];
      wcfg(8'h04, {7'h0, b[0], 1'h0, b[1], 6'h0});
      {go, kind} = {1'h0, 3'(i % 7)};
      @(posedge CLOCK_IN) #1 go = 1'h1;
      @(posedge CLOCK_IN) #1 go = 1'h0;
      @(posedge CLOCK_IN) #1;
      chk("fault out", {15'h0, b[0] && (kind == 3'h0 || kind == 3'h6)}, {15'h0, SYSTEM_FAULT_OUT});
      chk("par enable", {15'h0, b[1]}, {15'h0, PARITY_RESPONSE_ENABLE_OUT});
      e = exp_st(kind, b[2], b[1], b[0]);
      rd(8'h06, e);
      wcfg(8'h06, 16'h0);
      rd(8'h06, e);
      wcfg(8'h06, 16'hffff);
      rd(8'h06, 16'h0210);
    end
    {NEWER_REV_COMPLIANCE_ENABLE_IN, INT_REQ_IN} = 2'h3;
    rd(8'h06, 16'h0218);
    chk("int out", 16'h1, {15'h0, INT_ASSERT_OUT});
    wcfg(8'h04, 16'h0400);
    rd(8'h06, 16'h0218);
    chk("int out", 16'h0, {15'h0, INT_ASSERT_OUT});
    rd(8'h04, 16'h0400);
    NEWER_REV_COMPLIANCE_ENABLE_IN = 1'h0;
    rd(8'h06, 16'h0210);
    finish_test;
  end
endmodule
`default_nettype wire
